// ==== rtl/cpr_core.sv ====
// core clock ratio configuration: strap decode, bypass and off modes
`default_nettype none
module cpr_core (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// strap pins and external qualifier
	input wire logic [5:0] ratio_strap_i,
	input wire logic bypass_qualifier_clock_i,
	// power management
	input wire logic [1:0] dynamic_freq_switching_i,
	// mode status
	output logic pll_enable_o,
	output logic bypass_o,
	output logic clocks_off_o,
	output logic strap_reserved_o,
	// ratio and clock enables
	output logic [5:0] core_mult_x2_o,
	output logic address_acknowledge_delay_o,
	output logic core_clk_en_o,
	output logic bus_clk_en_o
);

	cpr_cfg_if cfg ();

	cpr_strap_capture u_capture (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ratio_strap_i(ratio_strap_i),
		.cfg(cfg)
	);

	// ----------------------------------------------------------------
	// strap decode
	// ----------------------------------------------------------------
	// multiplier lookup is shared with the checks through the package
	wire [5:0] strap_mult_x2 = cpr_pkg::cpr_ratio_x2(cfg.strap);
	wire is_bypass = (cfg.strap == cpr_pkg::STRAP_BYPASS);
	wire is_off = (cfg.strap == cpr_pkg::STRAP_OFF);
	// an unlisted code is treated as off so nothing runs at a wild ratio
	wire is_reserved = !is_bypass && !is_off &&
		(strap_mult_x2 == cpr_pkg::MULT_NONE);

	// frequency switching lowers the core multiplier by a shift
	wire dfs_on = (dynamic_freq_switching_i != cpr_pkg::DFS_NONE);
	wire [1:0] dfs_shift = (dynamic_freq_switching_i == cpr_pkg::DFS_HALF)
		? cpr_pkg::SHIFT_HALF : cpr_pkg::SHIFT_QUARTER;
	wire [5:0] eff_mult_x2 = dfs_on ? (strap_mult_x2 >> dfs_shift)
		: strap_mult_x2;
	wire ack_delay = (eff_mult_x2 < cpr_pkg::MULT_ACK_LIMIT);

	// mode selection
	cpr_pkg::cpr_mode_type mode_ff;
	cpr_pkg::cpr_mode_type nxt_mode;
	assign nxt_mode = !cfg.captured ? cpr_pkg::MODE_IDLE
		: is_bypass ? cpr_pkg::MODE_BYPASS
		: (is_off || is_reserved) ? cpr_pkg::MODE_OFF
		: cpr_pkg::MODE_PLL;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_ff <= cpr_pkg::MODE_IDLE;
		end
		else
		begin
			mode_ff <= nxt_mode;
		end
	end

	// ----------------------------------------------------------------
	// bypass bus divider
	// ----------------------------------------------------------------
	// qualifier is sampled as a synchronous input; its rising edge gives
	// the half-rate bus enable, so bus phase follows the board's qualifier
	logic qual_prev_ff;
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			qual_prev_ff <= 1'b0;
		end
		else
		begin
			qual_prev_ff <= bypass_qualifier_clock_i;
		end
	end
	wire qual_rise = bypass_qualifier_clock_i && !qual_prev_ff;

	// ----------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------
	wire nxt_pll = (nxt_mode == cpr_pkg::MODE_PLL);
	wire nxt_byp = (nxt_mode == cpr_pkg::MODE_BYPASS);
	wire nxt_off = (nxt_mode == cpr_pkg::MODE_OFF);
	wire nxt_core_en = nxt_pll || nxt_byp;
	wire nxt_bus_en = nxt_pll || (nxt_byp && qual_rise);
	wire [5:0] nxt_mult = nxt_pll ? eff_mult_x2 : cpr_pkg::RST_MULT;

	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pll_enable_o <= cpr_pkg::RST_FLAG;
			bypass_o <= cpr_pkg::RST_FLAG;
			clocks_off_o <= cpr_pkg::RST_FLAG;
			strap_reserved_o <= cpr_pkg::RST_FLAG;
			core_mult_x2_o <= cpr_pkg::RST_MULT;
			address_acknowledge_delay_o <= cpr_pkg::RST_FLAG;
			core_clk_en_o <= cpr_pkg::RST_FLAG;
			bus_clk_en_o <= cpr_pkg::RST_FLAG;
		end
		else
		begin
			pll_enable_o <= nxt_pll;
			bypass_o <= nxt_byp;
			clocks_off_o <= nxt_off;
			strap_reserved_o <= cfg.captured && is_reserved;
			core_mult_x2_o <= nxt_mult;
			address_acknowledge_delay_o <= nxt_pll && ack_delay;
			core_clk_en_o <= nxt_core_en;
			bus_clk_en_o <= nxt_bus_en;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_off_no_clock: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == cpr_pkg::MODE_OFF) |->
			!core_clk_en_o && !bus_clk_en_o && !pll_enable_o)
		else $error("clocking seen in off mode");

	chk_bypass_core_full: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == cpr_pkg::MODE_BYPASS) |->
			core_clk_en_o && !pll_enable_o && bypass_o)
		else $error("bypass core enable or loop state wrong");

	chk_bypass_bus_half: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == cpr_pkg::MODE_BYPASS) && $past(mode_ff ==
			cpr_pkg::MODE_BYPASS) && bus_clk_en_o |=> !bus_clk_en_o)
		else $error("bypass bus enable faster than half rate");

	chk_bypass_bus_qual: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(nxt_mode == cpr_pkg::MODE_BYPASS) && bypass_qualifier_clock_i &&
			!qual_prev_ff |=> bus_clk_en_o)
		else $error("bus enable missed qualifier edge");

	chk_ratio_range: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		pll_enable_o && dynamic_freq_switching_i == cpr_pkg::DFS_NONE &&
			$stable(dynamic_freq_switching_i) |->
			core_mult_x2_o >= 6'h16 && core_mult_x2_o <= 6'h38 &&
			core_mult_x2_o == cpr_pkg::cpr_ratio_x2(cfg.strap))
		else $error("core multiplier out of the strap table");

	chk_dfs_altered: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		$past(nxt_pll) && $past(dfs_on) |->
			core_mult_x2_o < $past(strap_mult_x2))
		else $error("multiplier not altered under frequency switching");

	chk_ack_delay_flag: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		pll_enable_o |->
			address_acknowledge_delay_o ==
			(core_mult_x2_o < cpr_pkg::MULT_ACK_LIMIT))
		else $error("acknowledge delay flag disagrees with ratio");

	chk_reserved_off: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		strap_reserved_o |-> clocks_off_o && !core_clk_en_o)
		else $error("reserved strap did not stop clocking");

	// nothing may run before the captured setting is marked as held
	chk_idle_outputs_quiet: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		(mode_ff == cpr_pkg::MODE_IDLE) |->
			!core_clk_en_o && !bus_clk_en_o && !pll_enable_o &&
			!bypass_o && !clocks_off_o)
		else $error("clocking before the strap setting was held");

	// ratio mode keeps core and bus running and no other mode flag up
	chk_pll_bus_steady: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		pll_enable_o |->
			core_clk_en_o && bus_clk_en_o && !bypass_o && !clocks_off_o)
		else $error("ratio mode enables or mode flags wrong");

	// without the loop there is no multiplier and no hold-off request
	chk_mult_zero_unlocked: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		!pll_enable_o |->
			(core_mult_x2_o == cpr_pkg::RST_MULT) &&
			!address_acknowledge_delay_o)
		else $error("multiplier shown while the loop is off");

	// exactly one operating mode at a time
	chk_mode_one_hot: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		$onehot(mode_ff))
		else $error("operating mode is not one-hot");

	// with switching idle the strap multiplier passes through unchanged
	chk_dfs_off_plain: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		$past(nxt_pll) && !$past(dfs_on) |->
			core_mult_x2_o == $past(strap_mult_x2))
		else $error("multiplier altered without frequency switching");

endmodule : cpr_core
`default_nettype wire

// ==== rtl/cpr_pkg.sv ====
// constants and strap decoding for the core clock ratio configuration
`default_nettype none
package cpr_pkg;

	// ----------------------------------------------------------------
	// strap field and multiplier widths
	// ----------------------------------------------------------------
	localparam int STRAP_W = 6;
	localparam int MULT_W = 6;
	localparam int DFS_W = 2;

	// ----------------------------------------------------------------
	// special strap encodings
	// ----------------------------------------------------------------
	localparam logic [5:0] STRAP_BYPASS = 6'h0C;
	localparam logic [5:0] STRAP_OFF = 6'h3C;

	// multiplier in half steps: value 22 means 11x
	localparam logic [5:0] MULT_NONE = 6'h00;
	// below 5x the bus logic must hold off the address acknowledge
	localparam logic [5:0] MULT_ACK_LIMIT = 6'h0A;

	// frequency switching codes; shift applied to the core multiplier
	localparam logic [1:0] DFS_NONE = 2'h0;
	localparam logic [1:0] DFS_HALF = 2'h1;
	localparam logic [1:0] SHIFT_HALF = 2'h1;
	localparam logic [1:0] SHIFT_QUARTER = 2'h2;

	// reset values of the outputs
	localparam logic RST_FLAG = 1'b0;
	localparam logic [5:0] RST_MULT = 6'h00;

	// operating mode, one-hot
	typedef enum logic [3:0] {
		MODE_IDLE = 4'h1,
		MODE_PLL = 4'h2,
		MODE_BYPASS = 4'h4,
		MODE_OFF = 4'h8
	} cpr_mode_type;

	// ratio strap to core multiplier in half steps, zero when not a ratio
	function automatic logic [5:0] cpr_ratio_x2(input logic [5:0] strap);
		logic [5:0] m;
		m = MULT_NONE;
		unique case (strap)
			6'h26: m = 6'h16;
			6'h00: m = 6'h17;
			6'h2E: m = 6'h18;
			6'h3E: m = 6'h19;
			6'h16: m = 6'h1A;
			6'h38: m = 6'h1B;
			6'h32: m = 6'h1C;
			6'h06: m = 6'h1E;
			6'h36: m = 6'h20;
			6'h02: m = 6'h22;
			6'h0A: m = 6'h24;
			6'h0E: m = 6'h28;
			6'h12: m = 6'h2A;
			6'h1A: m = 6'h30;
			6'h3A: m = 6'h38;
			default: m = MULT_NONE;
		endcase
		return m;
	endfunction : cpr_ratio_x2

endpackage : cpr_pkg
`default_nettype wire

// ==== rtl/cpr_cfg_if.sv ====
// captured strap setting passed from the capture stage to the decoder
`default_nettype none
interface cpr_cfg_if;
	logic [5:0] strap;
	logic captured;
	modport src (output strap, output captured);
	modport dst (input strap, input captured);
endinterface : cpr_cfg_if
`default_nettype wire

// ==== rtl/cpr_strap_capture.sv ====
// samples the ratio strap during reset and holds it afterwards
`default_nettype none
module cpr_strap_capture (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// strap pins
	input wire logic [5:0] ratio_strap_i,
	// captured setting
	cpr_cfg_if.src cfg
);

	logic [5:0] strap_ff;
	logic captured_ff;

	// ----------------------------------------------------------------
	// capture
	// ----------------------------------------------------------------
	// no async reset here: the strap is a port, so it is loaded by clock
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			strap_ff <= ratio_strap_i;
		end
	end

	// flags the setting as held from the first edge after release
	always_ff @(posedge clk_sys_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			captured_ff <= 1'b0;
		end
		else
		begin
			captured_ff <= 1'b1;
		end
	end

	assign cfg.strap = strap_ff;
	assign cfg.captured = captured_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_strap_held: assert property (
		@(posedge clk_sys_i) disable iff (rst_i)
		$past(captured_ff) |-> $stable(strap_ff))
		else $error("strap setting changed outside reset");

endmodule : cpr_strap_capture
`default_nettype wire

// ==== verification/cpr_board_model.sv ====
// board side model: qualifier clock source for bypass mode
`default_nettype none
module cpr_board_model (
	// clock and control
	input wire logic clk_sys_i,
	input wire logic run_i,
	// qualifier to the device
	output logic bypass_qualifier_clock_o = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// the bus rate, half the system clock; stands low outside test use so no stray edges
	// reach the device in normal operation
	always @(posedge clk_sys_i)
	begin
		bypass_qualifier_clock_o <= run_i & ~bypass_qualifier_clock_o;
	end
endmodule : cpr_board_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the core clock ratio configuration
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// stimulus, observation and bookkeeping
	// ----------------------------------------------------------------
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic run = 1'b0;
	logic [5:0] strap = 6'h00;
	logic [1:0] dynamic_freq_switching = 2'h0;
	logic [1:0] d;
	logic qual, pll, byp, off, res, ack, core_en, bus_en;
	logic [5:0] mult;
	// packed outputs, same field order as the queued notes
	wire [12:0] seen_vec = {pll, byp, off, res, mult, ack, core_en, bus_en};
	logic [12:0] exp_q[$];
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 32'h3307F764;
	// listed straps and their multipliers in half steps
	logic [5:0] st[15] = '{6'h26, 6'h00, 6'h2E, 6'h3E, 6'h16, 6'h38,
		6'h32, 6'h06, 6'h36, 6'h02, 6'h0A, 6'h0E, 6'h12, 6'h1A, 6'h3A};
	logic [5:0] mx[15] = '{6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B,
		6'h1C, 6'h1E, 6'h20, 6'h22, 6'h24, 6'h28, 6'h2A, 6'h30, 6'h38};
	initial
	begin
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	cpr_board_model board (
		.clk_sys_i(clk_sys_i),
		.run_i(run),
		.bypass_qualifier_clock_o(qual)
	);
	cpr_core dut (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.ratio_strap_i(strap),
		.bypass_qualifier_clock_i(qual),
		.dynamic_freq_switching_i(dynamic_freq_switching),
		.pll_enable_o(pll),
		.bypass_o(byp),
		.clocks_off_o(off),
		.strap_reserved_o(res),
		.core_mult_x2_o(mult),
		.address_acknowledge_delay_o(ack),
		.core_clk_en_o(core_en),
		.bus_clk_en_o(bus_en)
	);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [12:0] seen, input logic [12:0] want);
		n_checks++;
		if (seen !== want)
		begin
			num_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	// pll mode outputs: shifted multiplier, ack hold-off below 5x
	function automatic logic [12:0] pll_vec(input logic [5:0] m,
		input logic [1:0] s);
		logic [5:0] e;
		e = (s == 2'h0) ? m : ((s == 2'h1) ? m >> 1 : m >> 2);
		return {4'h8, e, e < 6'h0A, 2'h3};
	endfunction : pll_vec
	// reset with a strap, then change the strap once reset is gone
	task automatic boot(input logic [5:0] code, input logic [12:0] want);
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		strap <= code;
		dynamic_freq_switching <= 2'h0;
		run <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		exp_q.push_back(13'h0000);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		strap <= ~code;
		exp_q.push_back(13'h0000);
		@(posedge clk_sys_i);
		exp_q.push_back(want);
	endtask : boot
	// ----------------------------------------------------------------
	// watcher: oldest note against what the outputs show
	// ----------------------------------------------------------------
	always @(negedge clk_sys_i)
	begin
		if (exp_q.size() > 0)
			check(seen_vec, exp_q.pop_front());
	end
	// hang guard, far above the roughly 150 cycles the run needs
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			num_errors++;
			end_sim();
		end
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		for (int i = 0; i < 15; i++)
		begin
			boot(st[i], pll_vec(mx[i], 2'h0));
			d = (i < 4) ? 2'(i) : 2'($random(seed));
			dynamic_freq_switching <= d;
			@(posedge clk_sys_i);
			exp_q.push_back(pll_vec(mx[i], d));
		end
		// bypass: switching request ignored, bus enable every other cycle
		boot(6'h0C, 13'h0802);
		dynamic_freq_switching <= 2'h3;
		run <= 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk_sys_i);
			exp_q.push_back({12'h401, 1'(i % 2)});
		end
		// off: nothing moves whatever arrives at the inputs
		boot(6'h3C, 13'h0400);
		run <= 1'b1;
		dynamic_freq_switching <= 2'h1;
		repeat (3)
		begin
			@(posedge clk_sys_i);
			exp_q.push_back(13'h0400);
		end
		// the only unlisted code shown, on purpose, to see it refused
		boot(6'h01, 13'h0600);
		repeat (2) @(posedge clk_sys_i);
		end_sim();
	end
endmodule : tb
`default_nettype wire
